// >>> rtl/olk_regs.svh
// Constants for the security erase and sector lock block
`ifndef OLK_REGS_SVH
`define OLK_REGS_SVH
`define OLK_OP_WRITE_UNLOCK 8'h06
`define OLK_OP_SEC_ERASE 8'h44
`define OLK_OP_GLOBAL_LOCK 8'h7E
`define OLK_OP_GLOBAL_UNLOCK 8'h98
`define OLK_OP_LOCK 8'h36
`define OLK_OP_UNLOCK 8'h39
`define OLK_OP_LOCK_READ 8'h3D
`define OLK_SEL_REG1 2'h1
`define OLK_SEL_REG2 2'h2
`define OLK_SEL_LSB 12
`define OLK_SEL_PAD_LSB 10
`define OLK_SECREG_BYTES 1024
`define OLK_NUM_REGIONS 64
`define OLK_REGION_LSB 16
`define OLK_STATUS_RESET 24'h400000
`define OLK_ERASE_TIME_US 40000
`define OLK_CLK_MHZ 10
`define OLK_ERASE_CYCLES (`OLK_ERASE_TIME_US * `OLK_CLK_MHZ)
`endif

// >>> rtl/olk_pkg.sv
// Types for the security erase and sector lock block
package olk_pkg;
   typedef enum logic [4:0] {
      OLK_IDLE = 5'h01,
      OLK_OPC = 5'h02,
      OLK_ADDR = 5'h04,
      OLK_RDOUT = 5'h08,
      OLK_SKIP = 5'h10
   } olk_state_t;
endpackage

// >>> rtl/olk_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module olk_sync #(
   parameter logic RST_VAL = 1'b0
) (
   // Clock
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Data
   input wire logic d,
   output logic q
);
   logic meta_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_q <= RST_VAL;
         q <= RST_VAL;
      end else if (ce) begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// >>> rtl/olk_erase_timer.sv
// Self-timed erase cycle counter
`timescale 1ns/10ps
`include "olk_regs.svh"
module olk_erase_timer #(
   parameter int unsigned CYCLES = `OLK_ERASE_CYCLES
) (
   // Clock
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Control
   input wire logic start,
   output logic busy,
   output logic done
);
   logic [31:0] cnt_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_q <= 32'h0;
         busy <= 1'b0;
         done <= 1'b0;
      end else if (ce) begin
         done <= 1'b0;
         if (start && !busy) begin
            cnt_q <= CYCLES - 32'h1;
            busy <= 1'b1;
         end else if (busy) begin
            if (cnt_q == 32'h0) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               cnt_q <= cnt_q - 32'h1;
            end
         end
      end
   end
endmodule

// >>> rtl/olk_top.sv
// Serial command decoder for security erase and region locks
`timescale 1ns/10ps
`include "olk_regs.svh"
module olk_top #(
   parameter int unsigned ERASE_CYCLES = `OLK_ERASE_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Serial link pins
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic si,
   output logic so,
   output logic so_oe_n,
   // Status bits
   input wire logic four_byte_mode,
   input wire logic otp_lock_first,
   input wire logic otp_lock_second,
   input wire logic per_region_protect_select,
   input wire logic protect_complement,
   input wire logic protect_top_bottom,
   input wire logic [3:0] protect_range_field,
   output logic write_latch_flag,
   output logic program_busy_flag,
   output logic status_bit_twenty_two,
   // Protection query from array control
   input wire logic [31:0] target_addr,
   output logic target_locked,
   // Security register erase strobe
   output logic secreg_erase_start,
   output logic [1:0] secreg_erase_sel,
   output logic secreg_erase_done
);
   logic cs_n_s, sclk_s, si_s;
   logic sclk_d1_q, cs_d1_q;
   logic sclk_rise, sclk_fall, cs_rise;
   olk_pkg::olk_state_t state_q;
   logic [7:0] opc_q;
   logic [31:0] addr_q;
   logic [5:0] bitcnt_q;
   logic [`OLK_NUM_REGIONS-1:0] lock_q;
   logic erase_go, tmr_busy, tmr_done;
   logic [1:0] sel_w;
   logic [5:0] addr_bits_w;

   olk_sync #(.RST_VAL(1'b1)) u_cs (.clk(clk), .rst_n(rst_n), .ce(ce),
      .d(cs_n), .q(cs_n_s));
   olk_sync u_ck (.clk(clk), .rst_n(rst_n), .ce(ce), .d(sclk), .q(sclk_s));
   olk_sync u_si (.clk(clk), .rst_n(rst_n), .ce(ce), .d(si), .q(si_s));

   // Region index of an address
   function automatic logic [5:0] region_of(input logic [31:0] a);
      region_of = a[`OLK_REGION_LSB +: 6];
   endfunction

   // Range protection from the status range fields
   function automatic logic range_hit(input logic [5:0] r,
         input logic cmp, input logic tb, input logic [3:0] bp);
      logic [6:0] span;
      logic in;
      span = 7'h0;
      in = 1'b0;
      if (bp != 4'h0) begin
         span = (bp >= 4'h7) ? 7'h40 : 7'(7'h1 << (bp - 4'h1));
      end
      if (tb) begin
         in = ({1'b0, r} < span);
      end else begin
         in = ({1'b0, r} >= (7'h40 - span));
      end
      range_hit = in ^ cmp;
   endfunction

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sclk_d1_q <= 1'b0;
         cs_d1_q <= 1'b1;
      end else if (ce) begin
         sclk_d1_q <= sclk_s;
         cs_d1_q <= cs_n_s;
      end
   end
   assign sclk_rise = sclk_s & ~sclk_d1_q & ~cs_n_s;
   assign sclk_fall = ~sclk_s & sclk_d1_q & ~cs_n_s;
   assign cs_rise = cs_n_s & ~cs_d1_q;
   assign addr_bits_w = four_byte_mode ? 6'd32 : 6'd24;
   assign sel_w = addr_q[`OLK_SEL_LSB +: 2];

   // Command shift state
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= olk_pkg::OLK_IDLE;
         opc_q <= 8'h00;
         addr_q <= 32'h0;
         bitcnt_q <= 6'h0;
      end else if (ce) begin
         if (cs_n_s) begin
            state_q <= olk_pkg::OLK_IDLE;
            bitcnt_q <= 6'h0;
         end else begin
            unique case (state_q)
               olk_pkg::OLK_IDLE: begin
                  state_q <= olk_pkg::OLK_OPC;
                  bitcnt_q <= 6'h0;
                  addr_q <= 32'h0;
               end
               olk_pkg::OLK_OPC: begin
                  if (sclk_rise) begin
                     opc_q <= {opc_q[6:0], si_s};
                     bitcnt_q <= bitcnt_q + 6'h1;
                     if (bitcnt_q == 6'd7) begin
                        bitcnt_q <= 6'h0;
                        case ({opc_q[6:0], si_s})
                           `OLK_OP_SEC_ERASE, `OLK_OP_LOCK,
                           `OLK_OP_UNLOCK, `OLK_OP_LOCK_READ:
                              state_q <= olk_pkg::OLK_ADDR;
                           default: state_q <= olk_pkg::OLK_SKIP;
                        endcase
                     end
                  end
               end
               olk_pkg::OLK_ADDR: begin
                  if (sclk_rise) begin
                     addr_q <= {addr_q[30:0], si_s};
                     bitcnt_q <= bitcnt_q + 6'h1;
                     if (bitcnt_q == addr_bits_w - 6'h1) begin
                        bitcnt_q <= 6'h0;
                        state_q <= (opc_q == `OLK_OP_LOCK_READ) ?
                           olk_pkg::OLK_RDOUT : olk_pkg::OLK_SKIP;
                     end
                  end
               end
               olk_pkg::OLK_RDOUT: state_q <= olk_pkg::OLK_RDOUT;
               olk_pkg::OLK_SKIP: begin
                  // Extra clocks break framing for opcode-only commands and for commands after their address
                  if (sclk_rise) begin
                     bitcnt_q <= 6'h1;
                  end
               end
            endcase
         end
      end
   end

   // exact framing
   // Valid framing: exact opcode or opcode plus address, no extra clocks
   logic frame_ok;
   assign frame_ok = cs_rise && (state_q == olk_pkg::OLK_SKIP) &&
      (bitcnt_q == 6'h0);

   assign erase_go = frame_ok && opc_q == `OLK_OP_SEC_ERASE &&
      write_latch_flag && !tmr_busy &&
      addr_q[`OLK_SEL_PAD_LSB +: 2] == 2'h0 &&
      ((sel_w == `OLK_SEL_REG1 && !otp_lock_first) ||
       (sel_w == `OLK_SEL_REG2 && !otp_lock_second));

   olk_erase_timer #(.CYCLES(ERASE_CYCLES)) u_tmr (
      .clk(clk), .rst_n(rst_n), .ce(ce),
      .start(erase_go), .busy(tmr_busy), .done(tmr_done));

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         write_latch_flag <= 1'b0;
      end else if (ce) begin
         if (erase_go) begin
            write_latch_flag <= 1'b0;
         end else if (frame_ok && opc_q == `OLK_OP_WRITE_UNLOCK &&
               !tmr_busy) begin
            write_latch_flag <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         secreg_erase_start <= 1'b0;
         secreg_erase_sel <= 2'h0;
         secreg_erase_done <= 1'b0;
         program_busy_flag <= 1'b0;
         status_bit_twenty_two <= 1'b0;
      end else if (ce) begin
         secreg_erase_start <= erase_go;
         if (erase_go) begin
            secreg_erase_sel <= sel_w;
         end
         secreg_erase_done <= tmr_done;
         program_busy_flag <= tmr_busy;
         status_bit_twenty_two <= 1'(`OLK_STATUS_RESET >> 22);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lock_q <= '1;
      end else if (ce && frame_ok && !tmr_busy) begin
         unique case (opc_q)
            `OLK_OP_GLOBAL_LOCK: lock_q <= '1;
            `OLK_OP_GLOBAL_UNLOCK: lock_q <= '0;
            `OLK_OP_LOCK: lock_q[region_of(addr_q)] <= 1'b1;
            `OLK_OP_UNLOCK: lock_q[region_of(addr_q)] <= 1'b0;
            default: lock_q <= lock_q;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         so <= 1'b0;
         so_oe_n <= 1'b1;
      end else if (ce) begin
         if (state_q == olk_pkg::OLK_RDOUT && !cs_n_s) begin
            so_oe_n <= 1'b0;
            if (sclk_fall) begin
               so <= lock_q[region_of(addr_q)];
            end
         end else begin
            so_oe_n <= 1'b1;
            so <= 1'b0;
         end
      end
   end

   // protection for array program and erase
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         target_locked <= 1'b1;
      end else if (ce) begin
         target_locked <= per_region_protect_select ?
            lock_q[region_of(target_addr)] :
            range_hit(region_of(target_addr), protect_complement,
                      protect_top_bottom, protect_range_field);
      end
   end

   AST_BUSY_ON_START: assert property (@(posedge clk) disable iff (!rst_n)
      ce && erase_go |=> ##1 program_busy_flag)
      else $error("busy flag not raised");
   AST_NO_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
      erase_go |-> write_latch_flag)
      else $error("erase without latch");
   AST_LATCH_CLR: assert property (@(posedge clk) disable iff (!rst_n)
      ce && erase_go |=> !write_latch_flag)
      else $error("latch not cleared");
   AST_OTP1: assert property (@(posedge clk) disable iff (!rst_n)
      erase_go && sel_w == `OLK_SEL_REG1 |-> !otp_lock_first)
      else $error("locked register erased");
   AST_SEL: assert property (@(posedge clk) disable iff (!rst_n)
      ce && erase_go |=> secreg_erase_sel == $past(sel_w) &&
      secreg_erase_start)
      else $error("bad selector");
   AST_GLOCK: assert property (@(posedge clk) disable iff (!rst_n)
      ce && frame_ok && !tmr_busy && opc_q == `OLK_OP_GLOBAL_LOCK
      |=> &lock_q)
      else $error("global lock failed");
   AST_GUNLOCK: assert property (@(posedge clk) disable iff (!rst_n)
      ce && frame_ok && !tmr_busy && opc_q == `OLK_OP_GLOBAL_UNLOCK
      |=> lock_q == '0)
      else $error("global unlock failed");
   AST_FRAME: assert property (@(posedge clk) disable iff (!rst_n)
      ce && $past(ce) && erase_go |-> $past(!cs_n_s) && cs_n_s)
      else $error("erase outside chip select rise");

   // Steps of an accepted erase, and accepted region lock and unlock commands
   sequence s_erase_accept;
      ce && erase_go;
   endsequence
   sequence s_start_pulse;
      secreg_erase_start && !write_latch_flag;
   endsequence
   sequence s_lock_cmd;
      ce && frame_ok && !tmr_busy && opc_q == `OLK_OP_LOCK;
   endsequence
   sequence s_unlock_cmd;
      ce && frame_ok && !tmr_busy && opc_q == `OLK_OP_UNLOCK;
   endsequence

   AST_START_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
      s_erase_accept |=> s_start_pulse)
      else $error("erase start strobe missing");
   AST_NOT_BUSY: assert property (@(posedge clk) disable iff (!rst_n)
      erase_go |-> !tmr_busy)
      else $error("erase accepted while busy");
   AST_BUSY_RUN: assert property (@(posedge clk) disable iff (!rst_n)
      ce && tmr_busy |=> program_busy_flag)
      else $error("busy flag low during erase");
   AST_BUSY_FALL: assert property (@(posedge clk) disable iff (!rst_n)
      ce && tmr_done |=> !program_busy_flag && secreg_erase_done)
      else $error("busy flag not released at end");
   AST_OTP2: assert property (@(posedge clk) disable iff (!rst_n)
      erase_go && sel_w == `OLK_SEL_REG2 |-> !otp_lock_second)
      else $error("locked second register erased");
   AST_PAD: assert property (@(posedge clk) disable iff (!rst_n)
      erase_go |-> addr_q[`OLK_SEL_PAD_LSB +: 2] == 2'h0)
      else $error("erase with bad pad bits");
   AST_LOCK_RESET: assert property (@(posedge clk)
      !rst_n |=> &lock_q)
      else $error("lock bits not set by reset");
   AST_LOCK_ONE: assert property (@(posedge clk) disable iff (!rst_n)
      s_lock_cmd |=> lock_q[region_of(addr_q)])
      else $error("individual lock failed");
   AST_UNLOCK_ONE: assert property (@(posedge clk) disable iff (!rst_n)
      s_unlock_cmd |=> !lock_q[region_of(addr_q)])
      else $error("individual unlock failed");
   AST_SO_OFF: assert property (@(posedge clk) disable iff (!rst_n)
      ce && cs_n_s |=> so_oe_n)
      else $error("output driven while deselected");
   AST_SO_ON: assert property (@(posedge clk) disable iff (!rst_n)
      ce && state_q == olk_pkg::OLK_RDOUT && !cs_n_s |=> !so_oe_n)
      else $error("lock read output not driven");
   AST_BIT22: assert property (@(posedge clk) disable iff (!rst_n)
      ce |=> status_bit_twenty_two)
      else $error("status bit twenty two low");
   AST_PROT_LOCK: assert property (@(posedge clk) disable iff (!rst_n)
      ce && per_region_protect_select && lock_q == '1
      |=> target_locked)
      else $error("locked region not protected");
   AST_PROT_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
      ce && !per_region_protect_select && !protect_complement &&
      protect_range_field == 4'hF |=> target_locked)
      else $error("range protection missing");
endmodule

// >>> test/olk_host_model.sv
// Host serial controller model that frames commands into the block
`timescale 1ns/10ps
module olk_host_model (
   // Clock
   input wire logic clk,
   // Serial link
   output logic cs_n,
   output logic sclk,
   output logic si,
   input wire logic so,
   input wire logic so_oe_n
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si = 1'b0;
   end
   // Half of an 800 ns link period
   task automatic half();
      repeat (4) @(posedge clk);
   endtask
   task automatic frame(input logic [39:0] bits, input int n,
                        input bit rd, output logic got);
      got = 1'bx;
      @(posedge clk);
      cs_n <= 1'b0;
      repeat (2) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         si <= bits[39 - i];
         half();
         sclk <= 1'b1;
         half();
         sclk <= 1'b0;
      end
      if (rd) begin
         half();
         sclk <= 1'b1;
         half();
         got = so_oe_n ? 1'bx : so;
         sclk <= 1'b0;
      end
      repeat (2) @(posedge clk);
      cs_n <= 1'b1;
      si <= ~si;
      repeat (8) @(posedge clk);
   endtask
endmodule

// >>> test/test_otp_erase_and_sector_lock.sv
// Self-checking bench for the security erase and region lock block
`timescale 1ns/10ps
module test_otp_erase_and_sector_lock;
   localparam int ECYC = 20;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic cs_n, sclk, si, so, so_oe_n, fbm, otp1, otp2, psel, compl, tb;
   logic wlf, busy, bit22, tlock, est, edone, g;
   logic [3:0] prange;
   logic [31:0] taddr;
   logic [1:0] esel;
   logic [1:0] exp_q[$];
   int failures = 0;
   int checks = 0;
   int cyc = 0;
   int bcnt = 0;
   integer seed = 32'h8F3F116B;
   always #50 clk = ~clk;
   olk_top #(.ERASE_CYCLES(ECYC)) uut (.clk(clk), .rst_n(rst_n),
      .ce(ce), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so),
      .so_oe_n(so_oe_n), .four_byte_mode(fbm), .otp_lock_first(otp1),
      .otp_lock_second(otp2), .per_region_protect_select(psel),
      .protect_complement(compl), .protect_top_bottom(tb),
      .protect_range_field(prange), .write_latch_flag(wlf),
      .program_busy_flag(busy), .status_bit_twenty_two(bit22),
      .target_addr(taddr), .target_locked(tlock),
      .secreg_erase_start(est), .secreg_erase_sel(esel),
      .secreg_erase_done(edone));
   olk_host_model host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .si(si),
      .so(so), .so_oe_n(so_oe_n));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      if (failures == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic send(input logic [7:0] op, input logic [31:0] a,
                       input int nab, input bit rd);
      host.frame({op, nab > 24 ? a : a << 8}, 8 + nab, rd, g);
   endtask
   task automatic cmd(input logic [7:0] op);
      host.frame({op, 32'h0}, 8, 1'b0, g);
   endtask
   task automatic erase(input logic [1:0] sel, input logic [1:0] pad,
                        input int nab, input bit ok);
      logic [31:0] a;
      a = $random(seed);
      a[13:10] = {sel, pad};
      if (ok) exp_q.push_back(sel);
      send(8'h44, a, nab, 1'b0);
      for (int i = 0; i < ECYC + 40 && !(ok && edone === 1'b1); i++)
         @(posedge clk);
      @(posedge clk);
      chk(busy, 1'b0);
   endtask
   task automatic probe(input logic [31:0] a, input logic e);
      taddr <= a;
      repeat (3) @(posedge clk);
      chk(tlock, e);
   endtask
   task automatic lk(input logic [31:0] a, input logic e);
      probe(a, e);
      send(8'h3D, a, fbm ? 32 : 24, 1'b1);
      chk(g, e);
   endtask
   // Erase starts paired with notes; busy length measured
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         failures++;
         report_and_stop();
      end
      if (est === 1'b1) begin
         if (exp_q.size() == 0) chk(1'b1, 1'b0);
         else chk(esel, exp_q.pop_front());
      end
      if (busy === 1'b1) bcnt++;
      else if (bcnt != 0) begin
         chk(bcnt, ECYC);
         bcnt = 0;
      end
   end
   initial begin
      logic [31:0] a;
      fbm = 1'b0;
      otp1 = 1'b0;
      otp2 = 1'b0;
      psel = 1'b1;
      compl = 1'b0;
      tb = 1'b0;
      prange = 4'h0;
      taddr = 32'h0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      probe($random(seed), 1'b1);
      chk({wlf, busy, bit22}, 3'b001);
      erase(2'h1, 2'h0, 24, 1'b0);
      for (int i = 0; i < 4; i++) begin
         fbm <= i[1];
         cmd(8'h06);
         chk(wlf, 1'b1);
         erase(i[0] ? 2'h2 : 2'h1, 2'h0, i[1] ? 32 : 24, 1'b1);
         chk(wlf, 1'b0);
      end
      cmd(8'h06);
      otp1 <= 1'b1;
      erase(2'h1, 2'h0, 32, 1'b0);
      otp1 <= 1'b0;
      otp2 <= 1'b1;
      erase(2'h2, 2'h0, 32, 1'b0);
      otp2 <= 1'b0;
      erase(2'h1, 2'h1, 32, 1'b0);
      erase(2'h3, 2'h0, 32, 1'b0);
      erase(2'h2, 2'h0, 31, 1'b0);
      host.frame({8'h44, 32'h0}, 7, 1'b0, g);
      fbm <= 1'b0;
      erase(2'h1, 2'h0, 32, 1'b0);
      chk(wlf, 1'b1);
      erase(2'h2, 2'h0, 24, 1'b1);
      cmd(8'h98);
      a = $random(seed);
      lk(a, 1'b0);
      send(8'h36, a, 24, 1'b0);
      lk(a, 1'b1);
      lk(a ^ 32'h0001_0000, 1'b0);
      fbm <= 1'b1;
      send(8'h39, a, 32, 1'b0);
      lk(a, 1'b0);
      cmd(8'h7E);
      lk(a, 1'b1);
      psel <= 1'b0;
      probe(a, 1'b0);
      prange <= 4'hF;
      probe(a, 1'b1);
      psel <= 1'b1;
      cmd(8'h98);
      probe(a, 1'b0);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      probe(a, 1'b1);
      chk(exp_q.size(), 0);
      report_and_stop();
   end
endmodule
